//--- design/wtc_top.sv
`default_nettype none
module wtc_top #(
    parameter int PRESCALE_DIV = wtc_pkg::PRESCALE_DIV
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic rtc_clkin,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [wtc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq
);
    import wtc_pkg::*;

    // ==========================================================
    // declarations
    // ==========================================================
    logic tick;                                  // one-second pulse
    wtc_time_type time_r, time_nxt, tick_time;   // running time, ticked value
    wtc_time_type alm1_r, alm1_nxt;              // time-of-day alarm
    wtc_time_type alm2_r, alm2_nxt;              // day and time alarm
    logic [SW_W-1:0] sw_r, sw_nxt;               // stopwatch count
    wtc_sw_state_type sw_st_r, sw_st_nxt;        // stopwatch state
    logic [IRQ_W-1:0] ien_r, ien_nxt;            // interrupt enables
    logic [IRQ_W-1:0] stat_r, stat_nxt;          // sticky flags
    logic [IRQ_W-1:0] ev;                        // events of this cycle
    logic sw_ev;                                 // stopwatch underflow event
    logic ack_r, ack_nxt;                        // bus acknowledge
    logic [31:0] rdat_r, rdat_nxt;               // registered read data
    logic req, wr;                               // new bus access, write of it

    // ==========================================================
    // crystal prescaler
    // ==========================================================
    wtc_prescale #(
        .DIV(PRESCALE_DIV)
    ) u_prescale (
        .mclk(mclk),
        .reset(reset),
        .xtal_in(rtc_clkin),
        .tick(tick)
    );

    // ==========================================================
    // bus decode
    // ==========================================================
    // ack_r gates req so one access is taken once, then ack drops
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = req & wb_we_i;

    // write strobe of one register offset, shared by every register below
    function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                    input logic [7:0] reg_adr);
        return w && (a == reg_adr);
    endfunction

    // ==========================================================
    // timekeeping next values
    // ==========================================================
    // carries ripple within one tick; a software load beats the tick
    always_comb begin
        tick_time = time_r;
        ev[IRQ_SEC] = 1'b0;
        ev[IRQ_MIN] = 1'b0;
        ev[IRQ_HOUR] = 1'b0;
        ev[IRQ_DAY] = 1'b0;
        if (tick) begin
            ev[IRQ_SEC] = 1'b1;
            if (time_r.sec == SEC_MAX) begin
                tick_time.sec = '0;
                ev[IRQ_MIN] = 1'b1;
                if (time_r.min == MIN_MAX) begin
                    tick_time.min = '0;
                    ev[IRQ_HOUR] = 1'b1;
                    if (time_r.hour == HOUR_MAX) begin
                        tick_time.hour = '0;
                        ev[IRQ_DAY] = 1'b1;
                        tick_time.day = time_r.day + 1'b1;   // 15 bits wrap
                    end else begin
                        tick_time.hour = time_r.hour + 1'b1;
                    end
                end else begin
                    tick_time.min = time_r.min + 1'b1;
                end
            end else begin
                tick_time.sec = time_r.sec + 1'b1;
            end
        end
        // alarms fire only when a tick lands on the match, not on loads
        // limitation: a load that lands with a tick still lets the ticked time match
        ev[IRQ_ALM1] = tick && ({tick_time.hour, tick_time.min, tick_time.sec} ==
                                {alm1_r.hour, alm1_r.min, alm1_r.sec});
        ev[IRQ_ALM2] = tick && (tick_time == alm2_r);
        // the stopwatch process owns its event, so ev keeps a single driver
        ev[IRQ_SWATCH] = sw_ev;
        time_nxt = tick_time;
        if (wr_hit(wr, wb_adr_i, ADR_TIME)) begin
            time_nxt = wtc_merge(time_r, wb_dat_i, wb_sel_i);
        end
    end

    // ==========================================================
    // stopwatch next values
    // ==========================================================
    // a load restarts the count; after underflow the count rests at zero
    always_comb begin
        sw_nxt = sw_r;
        sw_st_nxt = sw_st_r;
        sw_ev = 1'b0;
        case (sw_st_r)
            SW_IDLE: begin
                sw_st_nxt = SW_IDLE;
            end
            SW_RUN: begin
                if (tick) begin
                    if (sw_r == '0) begin
                        sw_ev = 1'b1;
                        sw_st_nxt = SW_IDLE;
                    end else begin
                        sw_nxt = sw_r - 1'b1;
                    end
                end
            end
            default: begin
                sw_st_nxt = SW_IDLE;
            end
        endcase
        if (wr_hit(wr, wb_adr_i, ADR_SWATCH)) begin
            sw_nxt = SW_W'(wtc_merge(32'(sw_r), wb_dat_i, wb_sel_i));
            sw_st_nxt = SW_RUN;
        end
    end

    // ==========================================================
    // control registers, flags and bus answer
    // ==========================================================
    // set wins over a write-one clear landing in the same cycle
    always_comb begin
        alm1_nxt = alm1_r;
        alm2_nxt = alm2_r;
        ien_nxt = ien_r;
        stat_nxt = stat_r;
        if (wr_hit(wr, wb_adr_i, ADR_ALARM1)) begin
            alm1_nxt = wtc_merge(alm1_r, wb_dat_i, wb_sel_i);
        end
        if (wr_hit(wr, wb_adr_i, ADR_ALARM2)) begin
            alm2_nxt = wtc_merge(alm2_r, wb_dat_i, wb_sel_i);
        end
        if (wr_hit(wr, wb_adr_i, ADR_IEN) && wb_sel_i[0]) begin
            ien_nxt = wb_dat_i[IRQ_W-1:0];
        end
        if (wr_hit(wr, wb_adr_i, ADR_ISTAT) && wb_sel_i[0]) begin
            stat_nxt = stat_r & ~wb_dat_i[IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | ev;
        // registered ack: one wait state, dropped in the cycle after it stood
        ack_nxt = req;
        // read data is captured at the taking edge, so it stands with ack
        rdat_nxt = rdat_r;
        if (req) begin
            case (wb_adr_i)
                ADR_TIME: rdat_nxt = time_r;
                ADR_ALARM1: rdat_nxt = alm1_r;
                ADR_ALARM2: rdat_nxt = alm2_r;
                ADR_SWATCH: rdat_nxt = 32'(sw_r);
                ADR_IEN: rdat_nxt = 32'(ien_r);
                ADR_ISTAT: rdat_nxt = 32'(stat_r);
                default: rdat_nxt = 32'h0000_0000;           // unmapped reads zero
            endcase
        end
    end

    // registers
    // one synchronous reset clears every register of the block together
    always_ff @(posedge mclk) begin
        if (reset) begin
            time_r <= TIME_RST;
            alm1_r <= TIME_RST;
            alm2_r <= TIME_RST;
            sw_r <= SW_RST;
            sw_st_r <= SW_IDLE;
            ien_r <= IEN_RST;
            stat_r <= IEN_RST;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            time_r <= time_nxt;
            alm1_r <= alm1_nxt;
            alm2_r <= alm2_nxt;
            sw_r <= sw_nxt;
            sw_st_r <= sw_st_nxt;
            ien_r <= ien_nxt;
            stat_r <= stat_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    // flags record events even when masked; the mask only gates irq
    assign irq = |(stat_r & ien_r);
    assign wb_ack_o = ack_r;
    // data output comes straight from flip-flops, never from the decode
    assign wb_dat_o = rdat_r;
endmodule
`default_nettype wire

//--- design/wtc_pkg.sv
`default_nettype none
// ==========================================================
// shared constants and types of the watch block
// ==========================================================
package wtc_pkg;
    // crystal rate and wanted tick rate, in hertz
    localparam int XTAL_HZ = 32768;
    localparam int TICK_HZ = 1;
    // crystal edges per one-second tick
    localparam int PRESCALE_DIV = XTAL_HZ / TICK_HZ;
    localparam int PRESCALE_W = 16;

    // ==========================================================
    // register byte offsets on the wishbone slave
    // ==========================================================
    localparam int ADR_W = 8;
    localparam logic [7:0] ADR_TIME = 8'h00;   // running time, write loads it
    localparam logic [7:0] ADR_ALARM1 = 8'h04; // time-of-day alarm
    localparam logic [7:0] ADR_ALARM2 = 8'h08; // day plus time alarm
    localparam logic [7:0] ADR_SWATCH = 8'h0c; // stopwatch load and count
    localparam logic [7:0] ADR_IEN = 8'h10;    // interrupt enables
    localparam logic [7:0] ADR_ISTAT = 8'h14;  // sticky flags, write one clears

    // ==========================================================
    // counter limits
    // ==========================================================
    localparam logic [5:0] SEC_MAX = 6'h3b;
    localparam logic [5:0] MIN_MAX = 6'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam int SW_W = 16;

    // ==========================================================
    // interrupt bit positions in enable and status registers
    // ==========================================================
    localparam int IRQ_SEC = 0;
    localparam int IRQ_MIN = 1;
    localparam int IRQ_HOUR = 2;
    localparam int IRQ_DAY = 3;
    localparam int IRQ_ALM1 = 4;
    localparam int IRQ_ALM2 = 5;
    localparam int IRQ_SWATCH = 6;
    localparam int IRQ_W = 7;

    // reset values
    localparam logic [31:0] TIME_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IEN_RST = 7'h00;
    localparam logic [SW_W-1:0] SW_RST = 16'h0000;

    // time of day and day number, one bus word exactly
    typedef struct packed {
        logic [14:0] day;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } wtc_time_type;

    // stopwatch control state
    typedef enum logic {
        SW_IDLE = 1'b0,
        SW_RUN = 1'b1
    } wtc_sw_state_type;

    // byte-lane merge of a bus write into an old word
    function automatic logic [31:0] wtc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction
endpackage
`default_nettype wire

//--- design/wtc_prescale.sv
`default_nettype none
// ==========================================================
// crystal synchroniser and divider to a one-second pulse
// ==========================================================
module wtc_prescale #(
    parameter int DIV = wtc_pkg::PRESCALE_DIV
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic xtal_in,
    output logic tick
);
    import wtc_pkg::*;

    logic sync1_r, sync2_r, prev_r;          // two-flop synchroniser, edge memory
    logic [PRESCALE_W-1:0] cnt_r, cnt_nxt;   // crystal edge counter
    logic tick_r, tick_nxt;                  // registered tick
    logic rise;                              // rising crystal edge

    // ==========================================================
    // next values
    // ==========================================================
    // the edge is taken from the second flop only, never the first
    always_comb begin
        rise = sync2_r & ~prev_r;
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (rise) begin
            if (cnt_r == PRESCALE_W'(DIV - 1)) begin
                cnt_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    // registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            sync1_r <= xtal_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule
`default_nettype wire

//--- bench/wtc_checker_assertions.sv
`default_nettype none
// ==========================================================
// port-level checker of the watch block
// ==========================================================
module wtc_checker #(
    parameter int PRESCALE_DIV = wtc_pkg::PRESCALE_DIV
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic rtc_clkin,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [wtc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq
);
    import wtc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // ==========================================================
    // helper logic
    // ==========================================================
    logic req; // new access being taken
    logic rd_req; // new read being taken
    logic clk_q_r, clk_q_nxt; // crystal level one cycle back
    logic [7:0] since_r, since_nxt; // cycles since the last crystal rise
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_req = req && !wb_we_i;

    // saturating count, so a stalled crystal never wraps into a false pass
    always_comb begin
        clk_q_nxt = rtc_clkin;
        since_nxt = (since_r == 8'hff) ? since_r : since_r + 8'h01;
        if (rtc_clkin && !clk_q_r) begin
            since_nxt = 8'h00;
        end
    end

    // registers only
    always_ff @(posedge mclk) begin
        clk_q_r <= reset ? 1'b0 : clk_q_nxt;
        since_r <= reset ? 8'hff : since_nxt;
    end

    // ==========================================================
    // assertions
    // ==========================================================
    a_ack_follows_req: assert property (req |=> wb_ack_o)
        else $error("no acknowledge one cycle after a request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(req))
        else $error("acknowledge without a request");
    a_unmapped_zero: assert property (rd_req && wb_adr_i > ADR_ISTAT
        |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_time_in_range: assert property (rd_req && wb_adr_i == ADR_TIME
        |=> wb_dat_o[5:0] <= SEC_MAX && wb_dat_o[11:6] <= MIN_MAX && wb_dat_o[16:12] <= HOUR_MAX)
        else $error("time field out of range");
    a_swatch_upper_zero: assert property (rd_req && wb_adr_i == ADR_SWATCH
        |=> wb_dat_o[31:16] == 16'h0) else $error("stopwatch upper half not zero");
    a_flags_upper_zero: assert property (rd_req && wb_adr_i == ADR_ISTAT
        |=> wb_dat_o[31:7] == 25'h0) else $error("status upper bits not zero");
    a_irq_masked_off: assert property (req && wb_we_i && wb_adr_i == ADR_IEN
        && wb_sel_i[0] && wb_dat_i[6:0] == 7'h00 |=> !irq)
        else $error("irq high with no enables");
    a_irq_rise_cause: assert property ($rose(irq) |-> since_r <= 8'h08
        || $past(req && wb_we_i && wb_adr_i == ADR_IEN))
        else $error("irq rose away from a tick or enable write");
endmodule

bind wtc_top wtc_checker #(.PRESCALE_DIV(PRESCALE_DIV)) chk (.mclk(mclk), .reset(reset),
    .rtc_clkin(rtc_clkin), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq));
`default_nettype wire

//--- bench/wtc_top_bench.sv
`default_nettype none
// ==========================================================
// self-checking bench of the watch block
// ==========================================================
module wtc_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import wtc_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic rtc_clkin = 1'b0;
    logic req = 1'b0; // drives both cyc and stb, they always move together
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o, q;
    logic ack, irq;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    // four crystal rises per tick keeps each second at 64 cycles
    wtc_top #(.PRESCALE_DIV(4)) uut (.mclk(mclk), .reset(reset), .rtc_clkin(rtc_clkin),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq));

    // ==========================================================
    // clocks and watchdog
    // ==========================================================
    initial forever #20 mclk = ~mclk;
    // crystal runs free, 16 cycles a period
    initial forever begin
        repeat (8) @(posedge mclk);
        rtc_clkin <= ~rtc_clkin;
    end
    // whole run needs under 1000 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end

    // ==========================================================
    // tasks
    // ==========================================================
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        req <= 1'b0;
        // a slave that never answers ends the run as a mismatch
        if (ack !== 1'b1) begin
            err_count++;
            results();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string name);
        bus(1'b0, a, 32'h0);
        check(name, q, e);
    endtask

    // clears every flag, then returns just after the next seconds tick
    task automatic wait_tick();
        int n;
        n = 0;
        bus(1'b1, ADR_ISTAT, 32'h7f);
        while (irq !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        if (n == 200) begin
            err_count++;
            results();
        end
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rd_chk(ADR_TIME, TIME_RST, "time_rst");
        rd_chk(ADR_IEN, 32'h0, "ien_rst");
        rd_chk(ADR_ISTAT, 32'h0, "istat_rst");
        rd_chk(ADR_SWATCH, 32'h0, "sw_rst");
        bus(1'b1, 8'h20, 32'hffffffff);
        rd_chk(8'h20, 32'h0, "unmapped");
        bus(1'b1, ADR_IEN, 32'h1);
        wait_tick();
        // last second of the last day: every counter carries
        bus(1'b1, ADR_TIME, {15'h7fff, 5'h17, 6'h3b, 6'h3b});
        wait_tick();
        rd_chk(ADR_TIME, 32'h0, "wrap");
        // both alarms still hold their reset value of zero, so the wrap matches them too
        rd_chk(ADR_ISTAT, 32'h3f, "rollover");
        // alarm one ignores the day, alarm two needs it
        bus(1'b1, ADR_ALARM1, {15'h0, 5'h0a, 6'h14, 6'h1f});
        bus(1'b1, ADR_ALARM2, {15'h5, 5'h0a, 6'h14, 6'h1f});
        bus(1'b1, ADR_TIME, {15'h5, 5'h0a, 6'h14, 6'h1e});
        wait_tick();
        rd_chk(ADR_ISTAT, 32'h31, "alarms");
        // only the alarm one enable: its flag alone must raise irq
        bus(1'b1, ADR_IEN, 32'h10);
        check("irq_alarm", {31'h0, irq}, 32'h1);
        bus(1'b1, ADR_IEN, 32'h1);
        bus(1'b1, ADR_ALARM2, {15'h6, 5'h0a, 6'h14, 6'h20});
        wait_tick();
        rd_chk(ADR_ISTAT, 32'h01, "day_miss");
        rd_chk(ADR_TIME, {15'h5, 5'h0a, 6'h14, 6'h20}, "seconds");
        // stopwatch from two: 1, 0, then underflow
        bus(1'b1, ADR_SWATCH, 32'h2);
        wait_tick();
        rd_chk(ADR_SWATCH, 32'h1, "sw_one");
        wait_tick();
        rd_chk(ADR_ISTAT, 32'h01, "sw_zero");
        wait_tick();
        rd_chk(ADR_ISTAT, 32'h41, "sw_under");
        rd_chk(ADR_SWATCH, 32'h0, "sw_stop");
        // enable gating and write-one-clear
        bus(1'b1, ADR_IEN, 32'h40);
        check("irq_on", {31'h0, irq}, 32'h1);
        bus(1'b1, ADR_IEN, 32'h0);
        check("irq_mask", {31'h0, irq}, 32'h0);
        bus(1'b1, ADR_IEN, 32'h40);
        bus(1'b1, ADR_ISTAT, 32'h40);
        check("irq_clr", {31'h0, irq}, 32'h0);
        rd_chk(ADR_ISTAT, 32'h01, "sticky");
        results();
    end
endmodule
`default_nettype wire
